// ===== hw/eeprom_pkg.sv
// Purpose: shared constants and state types of the two-wire eeprom slave port
// Assumes: 20 MHz reference clock, 2048 x 8 array outside this block
// Notes:   programming time is expressed in milliseconds and derived into cycles
package eeprom_pkg;

  // array geometry
  localparam int ADDR_W  = 11;            // 8 blocks of 256 bytes
  localparam int WORD_W  = 8;             // byte-wide transfers
  localparam int BLK_W   = 3;             // block select bits in the device address
  localparam int PAGE_W  = 4;             // low address bits that roll inside a page
  localparam int PAGE_N  = 16;            // bytes held for one programming cycle
  localparam int CNT_W   = 5;             // byte count 0..16

  // device address decode
  localparam logic [3:0] DEV_CODE  = 4'ha;   // memory class code 1010
  localparam logic [3:0] BIT_LAST  = 4'h8;   // bits per byte before the ack clock
  localparam logic [7:0] IDLE_BYTE = 8'hff;  // released line when no data is ready

  // programming time
  localparam int REF_CLK_HZ  = 20_000_000;
  localparam int T_WR_MS     = 10;        // longest programming time
  localparam int T_WR_CYCLES = REF_CLK_HZ / 1000 * T_WR_MS;

  // link-side sequencer, one state per byte phase
  typedef enum logic [3:0] {
    L_IDLE      = 4'h0,
    L_DEV       = 4'h1,
    L_DEV_ACK   = 4'h2,
    L_WORD      = 4'h3,
    L_WORD_ACK  = 4'h4,
    L_WDATA     = 4'h5,
    L_WDATA_ACK = 4'h6,
    L_RDATA     = 4'h7,
    L_RDATA_ACK = 4'h8
  } link_st_t;

  // array-side sequencer
  typedef enum logic [1:0] {
    R_IDLE  = 2'h0,
    R_WRITE = 2'h1,
    R_WAIT  = 2'h2
  } ref_st_t;

endpackage

// ===== hw/prog_timer_if.sv
// Purpose: carries the start, load value and busy level of the programming timer
// Assumes: both ends sit on the reference clock
// Notes:   load is sampled only on the start pulse
`timescale 1ns/10ps
interface prog_timer_if #(
  parameter int CNT_W = 18
);
  logic             start;
  logic [CNT_W-1:0] load;
  logic             busy;

  modport timer (input start, input load, output busy);
  modport user  (output start, output load, input busy);
endinterface

// ===== hw/bus_sync.sv
// Purpose: two-flop synchroniser for a group of independent levels
// Assumes: each bit is a level or a toggle, never a multi-bit word
// Notes:   no reset, the chain flushes within two edges
`timescale 1ns/10ps
module bus_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_t;

  sync_t r_r;
  sync_t r_nxt;

  initial begin
    if (W < 1) $error("bus_sync width must be at least one");
  end

  // first stage feeds only the second
  always_comb begin
    r_nxt.s1 = d_i;
    r_nxt.s2 = r_r.s1;
  end

  always_ff @(posedge clk_i) begin
    r_r <= r_nxt;
  end

  assign q_o = r_r.s2;

endmodule

// ===== hw/prog_timer.sv
// Purpose: down-counter that times the internal programming cycle
// Assumes: start is a one-cycle pulse from the array-side sequencer
// Notes:   busy rises on the edge after start and falls when the count runs out
`timescale 1ns/10ps
module prog_timer #(
  parameter int CNT_W = 18
) (
  input  wire logic  ref_clk_i,
  input  wire logic  rst_n_i,
  prog_timer_if.timer tmr
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } tmr_t;

  tmr_t r_r;
  tmr_t r_nxt;

  initial begin
    if (CNT_W < 1) $error("prog_timer needs a counter of at least one bit");
  end

  // restart wins over a running count
  always_comb begin
    r_nxt = r_r;
    if (tmr.start) begin
      r_nxt.cnt = tmr.load;
    end else if (r_r.cnt != '0) begin
      r_nxt.cnt = r_r.cnt - 1'b1;
    end
    if (!rst_n_i) begin
      r_nxt = '0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    r_r <= r_nxt;
  end

  assign tmr.busy = (r_r.cnt != '0);

endmodule

// ===== hw/two_wire_eeprom_slave_port.sv
// Purpose: two-wire serial slave front end of a 2048 x 8 nonvolatile memory
// Assumes: scl/sda oversampled on link_clk_i; array port on ref_clk_i
// Notes:   read data is fetched ahead, ready well inside one scl low phase
//
// Overview of operation
// - sda falling with scl high starts transaction
// - sda rising with scl high is stop
// - stop during read returns to idle
// - stop after write data launches programming cycle
// - sda changes with scl high are conditions
// - eight bits, receiver acks on ninth clock
// - busy programming: ignore bus, never ack
// - answer only to class code 1010
// - three block bits give upper address bits
// - byte write: address, word, data, stop
// - up to sixteen bytes per write
// - ack each byte, program received count up to sixteen
// - only low four bits roll while writing
// - write protect high suppresses all writes
// - counter holds last address plus one
// - read ignores block bits, uses counter
// - read counter steps at eighth falling edge
// - master ack continues with next address
// - read counter wraps at array end
`timescale 1ns/10ps
module two_wire_eeprom_slave_port
  import eeprom_pkg::*;
#(
  parameter int T_WR_CYCLES_P = T_WR_CYCLES
) (
  input  wire logic              ref_clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              link_clk_i,
  input  wire logic              scl_i,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe_n_o,
  input  wire logic              wp_i,
  output logic                   mem_rd_o,
  output logic                   mem_wr_o,
  output logic [ADDR_W-1:0]      mem_addr_o,
  output logic [WORD_W-1:0]      mem_wdata_o,
  input  wire logic [WORD_W-1:0] mem_rdata_i,
  output logic                   prog_busy_o
);

  localparam int TMR_W = $clog2(T_WR_CYCLES_P + 1);

  initial begin
    if (T_WR_CYCLES_P < 1) $error("programming time must be at least one cycle");
  end

  // link domain state
  typedef struct packed {
    link_st_t                       st;
    logic [3:0]                     bits;     // bits seen in the current byte
    logic [WORD_W-1:0]              sh;       // receive or transmit shifter
    logic [BLK_W-1:0]               blk;      // block bits of the last device address, read or write
    logic [ADDR_W-1:0]              ctr;      // address counter
    logic [ADDR_W-1:0]              wr_base;  // first address of this write
    logic [CNT_W-1:0]               n_bytes;  // data bytes taken, saturates at 16
    logic [PAGE_N-1:0][WORD_W-1:0]  pbuf;     // page buffer
    logic                           drive;    // pull sda low
    logic                           mack;     // master acked the read byte
    logic                           scl_q;
    logic                           sda_q;
    logic                           prog_req; // toggle to array side
    logic                           rd_req;   // toggle to array side
    logic [ADDR_W-1:0]              rd_addr;
  } lnk_t;

  // array domain state
  typedef struct packed {
    ref_st_t           st;
    logic              prog_ack;  // toggle back to link side
    logic              rd_ack;
    logic              rd_seen;
    logic              rd_pend;
    logic [WORD_W-1:0] rd_data;
    logic [CNT_W-1:0]  idx;
    logic              mem_rd;
    logic              mem_wr;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
    logic              tmr_start;
    logic              busy;
  } arr_t;

  lnk_t l_r;
  lnk_t l_nxt;
  arr_t a_r;
  arr_t a_nxt;

  logic [1:0] pin_s;
  logic [2:0] l_in_s;
  logic [2:0] a_in_s;

  prog_timer_if #(.CNT_W(TMR_W)) tmr_if ();

  // pins and handshake toggles into the link domain
  bus_sync #(.W(2)) u_pin_sync (
    .clk_i (link_clk_i),
    .d_i   ({scl_i, sda_i}),
    .q_o   (pin_s)
  );

  bus_sync #(.W(3)) u_link_sync (
    .clk_i (link_clk_i),
    .d_i   ({rst_n_i, a_r.prog_ack, a_r.rd_ack}),
    .q_o   (l_in_s)
  );

  // toggles and the protect pin into the array domain
  bus_sync #(.W(3)) u_arr_sync (
    .clk_i (ref_clk_i),
    .d_i   ({l_r.prog_req, l_r.rd_req, wp_i}),
    .q_o   (a_in_s)
  );

  prog_timer #(.CNT_W(TMR_W)) u_timer (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .tmr       (tmr_if.timer)
  );

  // link-side decode of the synchronised pins
  logic scl;
  logic sda;
  logic lrst_n;
  logic prog_ack_s;
  logic rd_ack_s;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic busy_l;
  logic [WORD_W-1:0] rd_byte;
  logic [PAGE_W-1:0] wr_lo;

  assign scl        = pin_s[1];
  assign sda        = pin_s[0];
  assign lrst_n     = l_in_s[2];
  assign prog_ack_s = l_in_s[1];
  assign rd_ack_s   = l_in_s[0];
  assign scl_rise   = scl & ~l_r.scl_q;
  assign scl_fall   = ~scl & l_r.scl_q;
  assign start_cond = scl & l_r.scl_q & l_r.sda_q & ~sda;
  assign stop_cond  = scl & l_r.scl_q & ~l_r.sda_q & sda;
  assign busy_l     = l_r.prog_req != prog_ack_s;          // open until array answers
  // a late fetch sends ones rather than a stale byte
  assign rd_byte    = (rd_ack_s == l_r.rd_req) ? a_r.rd_data : IDLE_BYTE;
  assign wr_lo      = l_r.ctr[PAGE_W-1:0];

  // link sequencer: one step per scl edge or bus condition
  always_comb begin
    l_nxt       = l_r;
    l_nxt.scl_q = scl;
    l_nxt.sda_q = sda;
    if (start_cond) begin
      // a start always resynchronises, even mid-byte
      l_nxt.drive   = 1'b0;
      l_nxt.bits    = '0;
      // a poll during the burst must not shrink the count being programmed
      l_nxt.n_bytes = busy_l ? l_r.n_bytes : '0;
      l_nxt.st      = busy_l ? L_IDLE : L_DEV;
    end else if (stop_cond) begin
      if ((l_r.st == L_WDATA || l_r.st == L_WDATA_ACK) && l_r.n_bytes != '0) begin
        l_nxt.prog_req = ~l_r.prog_req;
      end
      l_nxt.drive = 1'b0;
      l_nxt.st    = L_IDLE;
    end else begin
      unique case (l_r.st)
        L_IDLE: begin
          l_nxt.drive = 1'b0;
        end
        L_DEV, L_WORD, L_WDATA: begin
          if (scl_rise && l_r.bits != BIT_LAST) begin
            l_nxt.sh   = {l_r.sh[WORD_W-2:0], sda};
            l_nxt.bits = l_r.bits + 4'h1;
          end else if (scl_fall && l_r.bits == BIT_LAST) begin
            l_nxt.bits = '0;
            if (l_r.st == L_DEV) begin
              if (l_r.sh[7:4] == DEV_CODE) begin
                l_nxt.drive = 1'b1;
                l_nxt.blk   = l_r.sh[3:1];
                l_nxt.st    = L_DEV_ACK;
                l_nxt.mack  = l_r.sh[0];                               // direction kept here
                if (l_r.sh[0]) begin
                  // fetch ahead from the counter, block bits unused
                  l_nxt.rd_addr = l_r.ctr;
                  l_nxt.rd_req  = ~l_r.rd_req;
                end
              end else begin
                l_nxt.st = L_IDLE;
              end
            end else if (l_r.st == L_WORD) begin
              l_nxt.ctr     = {l_r.blk, l_r.sh};
              l_nxt.wr_base = {l_r.blk, l_r.sh};
              l_nxt.drive   = 1'b1;
              l_nxt.st      = L_WORD_ACK;
            end else begin
              // later bytes overwrite once the page has wrapped
              l_nxt.pbuf[wr_lo] = l_r.sh;
              l_nxt.ctr = {l_r.ctr[ADDR_W-1:PAGE_W], wr_lo + 4'h1};
              if (l_r.n_bytes != CNT_W'(PAGE_N)) begin
                l_nxt.n_bytes = l_r.n_bytes + 5'h01;
              end
              l_nxt.drive = 1'b1;
              l_nxt.st    = L_WDATA_ACK;
            end
          end
        end
        L_DEV_ACK: begin
          if (scl_fall) begin
            if (l_r.mack) begin
              l_nxt.sh    = rd_byte;
              l_nxt.drive = ~rd_byte[7];
              l_nxt.st    = L_RDATA;
            end else begin
              l_nxt.drive = 1'b0;
              l_nxt.st    = L_WORD;
            end
          end
        end
        L_WORD_ACK, L_WDATA_ACK: begin
          if (scl_fall) begin
            l_nxt.drive = 1'b0;
            l_nxt.st    = L_WDATA;
          end
        end
        L_RDATA: begin
          if (scl_rise) begin
            l_nxt.bits = l_r.bits + 4'h1;
          end else if (scl_fall) begin
            if (l_r.bits == BIT_LAST) begin
              // counter steps here and wraps at the top of the array
              l_nxt.ctr     = l_r.ctr + 11'h001;
              l_nxt.rd_addr = l_r.ctr + 11'h001;
              l_nxt.rd_req  = ~l_r.rd_req;
              l_nxt.bits    = '0;
              l_nxt.drive   = 1'b0;
              l_nxt.st      = L_RDATA_ACK;
            end else begin
              l_nxt.sh    = {l_r.sh[WORD_W-2:0], 1'b1};
              l_nxt.drive = ~l_r.sh[6];
            end
          end
        end
        L_RDATA_ACK: begin
          if (scl_rise) begin
            l_nxt.mack = ~sda;
          end else if (scl_fall) begin
            if (l_r.mack) begin
              l_nxt.sh    = rd_byte;
              l_nxt.drive = ~rd_byte[7];
              l_nxt.st    = L_RDATA;
            end else begin
              l_nxt.st = L_IDLE;
            end
          end
        end
        default: begin
          l_nxt.drive = 1'b0;
          l_nxt.st    = L_IDLE;
        end
      endcase
    end
    if (!lrst_n) begin
      l_nxt = '0;
    end
  end

  always_ff @(posedge link_clk_i) begin
    l_r <= l_nxt;
  end

  // array-side decode
  logic              prog_req_s;
  logic              rd_req_s;
  logic              wp_s;
  logic [PAGE_W-1:0] prog_lo;

  assign prog_req_s = a_in_s[2];
  assign rd_req_s   = a_in_s[1];
  assign wp_s       = a_in_s[0];
  assign prog_lo    = l_r.wr_base[PAGE_W-1:0] + a_r.idx[PAGE_W-1:0];

  assign tmr_if.start = a_r.tmr_start;
  assign tmr_if.load  = TMR_W'(T_WR_CYCLES_P);

  // array sequencer: fetch ahead for reads, burst the page then time it
  always_comb begin
    a_nxt           = a_r;
    a_nxt.mem_rd    = 1'b0;
    a_nxt.mem_wr    = 1'b0;
    a_nxt.tmr_start = 1'b0;
    // read words are stable on the link side while the toggles match
    if (a_r.rd_pend) begin
      a_nxt.rd_data = mem_rdata_i;
      a_nxt.rd_ack  = a_r.rd_seen;
      a_nxt.rd_pend = 1'b0;
    end else if (rd_req_s != a_r.rd_seen && a_r.st == R_IDLE) begin
      a_nxt.rd_seen = rd_req_s;
      a_nxt.rd_pend = 1'b1;
      a_nxt.mem_rd  = 1'b1;
      a_nxt.addr    = l_r.rd_addr;
    end
    unique case (a_r.st)
      R_IDLE: begin
        if (prog_req_s != a_r.prog_ack && !a_r.rd_pend) begin
          if (wp_s) begin
            a_nxt.prog_ack = prog_req_s;
          end else begin
            a_nxt.idx  = '0;
            a_nxt.busy = 1'b1;
            a_nxt.st   = R_WRITE;
          end
        end
      end
      R_WRITE: begin
        if (a_r.idx == l_r.n_bytes) begin
          a_nxt.tmr_start = 1'b1;
          a_nxt.st        = R_WAIT;
        end else begin
          // only the low bits roll, from the first address given
          a_nxt.mem_wr = 1'b1;
          a_nxt.addr   = {l_r.wr_base[ADDR_W-1:PAGE_W], prog_lo};
          a_nxt.wdata  = l_r.pbuf[prog_lo];
          a_nxt.idx    = a_r.idx + 5'h01;
        end
      end
      R_WAIT: begin
        // link stays deaf until this toggle lands
        if (!a_r.tmr_start && !tmr_if.busy) begin
          a_nxt.prog_ack = prog_req_s;
          a_nxt.busy     = 1'b0;
          a_nxt.st       = R_IDLE;
        end
      end
      default: begin
        a_nxt.busy = 1'b0;
        a_nxt.st   = R_IDLE;
      end
    endcase
    if (!rst_n_i) begin
      a_nxt = '0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    a_r <= a_nxt;
  end

  // open-drain pin: only ever pulls low
  assign sda_o       = 1'b0;
  assign sda_oe_n_o  = ~l_r.drive;
  assign mem_rd_o    = a_r.mem_rd;
  assign mem_wr_o    = a_r.mem_wr;
  assign mem_addr_o  = a_r.addr;
  assign mem_wdata_o = a_r.wdata;
  assign prog_busy_o = a_r.busy;

endmodule

// ===== bench/eeprom_port_monitor.sv
// Purpose: concurrent checks on the ports of the two-wire eeprom slave port
// Assumes: scl low phases far longer than the three link edges of answer delay
// Notes:   busy length checked by a helper counter, not by repetition
`timescale 1ns/10ps
module eeprom_port_monitor
  import eeprom_pkg::*;
#(
  parameter int T_WR_CYCLES_P = T_WR_CYCLES
) (
  input wire logic              ref_clk_i,
  input wire logic              rst_n_i,
  input wire logic              link_clk_i,
  input wire logic              scl_i,
  input wire logic              sda_i,
  input wire logic              sda_o,
  input wire logic              sda_oe_n_o,
  input wire logic              wp_i,
  input wire logic              mem_rd_o,
  input wire logic              mem_wr_o,
  input wire logic [ADDR_W-1:0] mem_addr_o,
  input wire logic [WORD_W-1:0] mem_wdata_o,
  input wire logic [WORD_W-1:0] mem_rdata_i,
  input wire logic              prog_busy_o
);
  logic [31:0] busy_len_r;

  // cycles spent busy, cleared while idle
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || !prog_busy_o)
      busy_len_r <= 32'h0;
    else
      busy_len_r <= busy_len_r + 32'h1;
  end

  AST_SDA_LOW_ONLY: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
    sda_o == 1'b0) else $error("sda output not a low drive");
  AST_OE_SCL_LOW: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
    $changed(sda_oe_n_o) |-> !scl_i) else $error("sda drive changed with scl high");
  AST_WR_WP: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    mem_wr_o |-> !wp_i) else $error("array written while protected");
  AST_WR_BUSY: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    mem_wr_o |=> prog_busy_o) else $error("write without busy window");
  AST_BUSY_LEN: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    $fell(prog_busy_o) |-> busy_len_r >= T_WR_CYCLES_P - 2 && busy_len_r <= T_WR_CYCLES_P + 40)
    else $error("busy window length wrong");
  AST_BUSY_NO_ACK: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    prog_busy_o |-> sda_oe_n_o) else $error("sda driven while busy");
  AST_RD_HOLD: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    mem_rd_o |=> !mem_rd_o && $stable(mem_addr_o)) else $error("read pulse or address unstable");
  AST_WR_STEP: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    mem_wr_o && $past(mem_wr_o) |-> mem_addr_o[3:0] == $past(mem_addr_o[3:0]) + 4'h1
    && mem_addr_o[10:4] == $past(mem_addr_o[10:4])) else $error("page address step wrong");
endmodule

bind two_wire_eeprom_slave_port eeprom_port_monitor #(.T_WR_CYCLES_P(T_WR_CYCLES_P)) mon_i (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .link_clk_i(link_clk_i), .scl_i(scl_i),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .wp_i(wp_i), .mem_rd_o(mem_rd_o),
  .mem_wr_o(mem_wr_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
  .mem_rdata_i(mem_rdata_i), .prog_busy_o(prog_busy_o));

// ===== bench/bus_master_model.sv
// Purpose: behavioural two-wire bus master driving scl and an open-drain sda
// Assumes: tasks are entered on a falling ref clock edge, quarter bit 600 ns
// Notes:   scl stands high between frames; sda released means pulled high
`timescale 1ns/10ps
module bus_master_model (
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_drv_o
);
  localparam int Q = 600;  // keeps scl low 1.2 us, room for read prefetch

  initial begin
    scl_o = 1'b1;
    sda_drv_o = 1'b1;
  end

  // sda falls while scl high, also as repeated start
  task automatic start();
    sda_drv_o = 1'b1;
    #(Q) scl_o = 1'b1;
    #(Q) sda_drv_o = 1'b0;
    #(Q) scl_o = 1'b0;
    #(Q);
  endtask

  // sda rises while scl high
  task automatic stop();
    sda_drv_o = 1'b0;
    #(Q) scl_o = 1'b1;
    #(Q) sda_drv_o = 1'b1;
    #(Q);
  endtask

  // eight bits msb first plus ack clock; data changes only with scl low
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      sda_drv_o = tx[i];
      #(Q) scl_o = 1'b1;
      #(Q) rx[i] = sda_i;
      #(Q) scl_o = 1'b0;
      #(Q);
    end
  endtask
endmodule

// ===== bench/test_two_wire_eeprom_slave_port.sv
// Purpose: self-checking bench of the two-wire eeprom slave port
// Assumes: short programming time parameter, array modelled here
// Notes:   rows hold byte writes; page, protect, wrap cases follow
`timescale 1ns/10ps
module test_two_wire_eeprom_slave_port
  import eeprom_pkg::*;
;
  localparam int TWR = 1000;
  `define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_errors++; \
    $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
  typedef struct { logic [2:0] blk; logic [7:0] wa; logic [7:0] d; logic [10:0] a; } row_t;
  row_t        rows [3] = '{'{3'h2, 8'ha5, 8'h3c, 11'h2a5}, '{3'h7, 8'hff, 8'hc3, 11'h7ff},
                            '{3'h0, 8'h00, 8'h81, 11'h000}};
  int          n_errors = 0;
  int          check_count = 0;
  logic        ref_clk, link_clk, rst_n, wp, scl, sda_m, sda_o, sda_oe_n;
  logic        mem_rd, mem_wr, prog_busy;
  logic [10:0] mem_addr;
  logic [7:0]  mem_wdata;
  logic [7:0]  mem_rdata = 8'h00;
  logic [7:0]  mem [2048];
  wire         sda_w = sda_m & (sda_oe_n | sda_o);  // pulled-up open-drain wire

  two_wire_eeprom_slave_port #(.T_WR_CYCLES_P(TWR)) two_wire_eeprom_slave_port_i (
    .ref_clk_i(ref_clk), .rst_n_i(rst_n), .link_clk_i(link_clk), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_n_o(sda_oe_n), .wp_i(wp), .mem_rd_o(mem_rd), .mem_wr_o(mem_wr),
    .mem_addr_o(mem_addr), .mem_wdata_o(mem_wdata), .mem_rdata_i(mem_rdata),
    .prog_busy_o(prog_busy));
  bus_master_model bus_master_model_i (.sda_i(sda_w), .scl_o(scl), .sda_drv_o(sda_m));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial begin
    link_clk = 1'b0;
    #1.7;
    forever #3 link_clk = ~link_clk;
  end

  // array model: read data ready the edge after the pulse
  always @(posedge ref_clk) if (mem_wr) mem[mem_addr] <= mem_wdata;
  always @(negedge ref_clk) if (mem_rd) mem_rdata <= mem[mem_addr];

  task automatic give_verdict();
    if (n_errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic xb(input logic [7:0] b, input logic a, output logic [7:0] rx, output logic ak);
    logic [8:0] r;
    bus_master_model_i.xfer({b, a}, r);
    rx = r[8:1];
    ak = r[0];
  endtask

  // write n bytes d0, d0+1, ...; n of zero is a dummy write
  task automatic wr(input logic [2:0] blk, input logic [7:0] wa, input logic [7:0] d0, input int n);
    logic [7:0] rx;
    logic       ak;
    bus_master_model_i.start();
    xb({DEV_CODE, blk, 1'b0}, 1'b1, rx, ak);
    `CHK(ak, 1'b0)
    xb(wa, 1'b1, rx, ak);
    `CHK(ak, 1'b0)
    for (int i = 0; i < n; i++) begin
      xb(d0 + i[7:0], 1'b1, rx, ak);
      `CHK(ak, 1'b0)
    end
    bus_master_model_i.stop();
  endtask

  // current address read of n bytes from a, block bits set to junk
  task automatic rd(input logic [10:0] a, input int n);
    logic [7:0]  rx;
    logic        ak;
    logic [10:0] x;
    bus_master_model_i.start();
    xb({DEV_CODE, 3'h5, 1'b1}, 1'b1, rx, ak);
    `CHK(ak, 1'b0)
    for (int i = 0; i < n; i++) begin
      x = a + i[10:0];
      xb(8'hff, i == n - 1, rx, ak);
      `CHK(rx, mem[x])
    end
    bus_master_model_i.stop();
  endtask

  // poll with read flag until acked, bounded
  task automatic poll(output int tries);
    logic [7:0] rx;
    logic       ak;
    logic       ak2;
    tries = 0;
    ak = 1'b1;
    while (ak !== 1'b0 && tries < 40) begin
      tries++;
      bus_master_model_i.start();
      xb({DEV_CODE, 3'h0, 1'b1}, 1'b1, rx, ak);
      if (ak === 1'b0)
        xb(8'hff, 1'b1, rx, ak2);
      bus_master_model_i.stop();
    end
    if (ak !== 1'b0) begin
      n_errors++;
      give_verdict();
    end
  endtask

  initial begin
    logic [7:0] rx;
    logic       ak;
    int         t;
    rst_n = 1'b0;
    wp = 1'b0;
    for (int i = 0; i < 2048; i++) mem[i] = i[7:0] ^ 8'h5a;
    repeat (5) @(negedge ref_clk);
    `CHK(sda_oe_n, 1'b1)
    `CHK(prog_busy, 1'b0)
    `CHK(mem_wr, 1'b0)
    rst_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    rd(11'h000, 2);
    // ordinary byte writes, each read back through a dummy write
    foreach (rows[k]) begin
      wr(rows[k].blk, rows[k].wa, rows[k].d, 1);
      poll(t);
      `CHK(t > 1, 1'b1)
      wr(rows[k].blk, rows[k].wa, 8'h00, 0);
      rd(rows[k].a, 1);
      `CHK(mem[rows[k].a], rows[k].d)
    end
    // foreign class code never acked
    bus_master_model_i.start();
    xb({4'hb, 3'h0, 1'b0}, 1'b1, rx, ak);
    `CHK(ak, 1'b1)
    bus_master_model_i.stop();
    // seventeen bytes from low nibble e: wraps and overwrites the first
    wr(3'h1, 8'h0e, 8'h10, 17);
    repeat (100) @(negedge ref_clk);
    `CHK(prog_busy, 1'b1)
    poll(t);
    `CHK(mem[11'h10e], 8'h20)
    `CHK(mem[11'h10f], 8'h11)
    `CHK(mem[11'h100], 8'h12)
    `CHK(mem[11'h10d], 8'h1f)
    `CHK(mem[11'h11e], 8'h44)
    // protected write is acked but leaves the array alone
    wp = 1'b1;
    repeat (10) @(negedge ref_clk);
    wr(3'h2, 8'ha5, 8'h77, 1);
    repeat (100) @(negedge ref_clk);
    `CHK(prog_busy, 1'b0)
    `CHK(mem[11'h2a5], 8'h3c)
    poll(t);
    `CHK(t, 1)
    wp = 1'b0;
    // sequential read across the array end
    wr(3'h7, 8'hff, 8'h00, 0);
    rd(11'h7ff, 2);
    // mid-run reset: outputs quiet and the address counter back at zero
    rst_n = 1'b0;
    repeat (5) @(negedge ref_clk);
    `CHK(sda_oe_n, 1'b1)
    `CHK(prog_busy, 1'b0)
    rst_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    rd(11'h000, 1);
    give_verdict();
  end

  // hang guard
  initial begin
    #4ms;
    n_errors++;
    give_verdict();
  end
endmodule
